// File: src/sacs_top.sv
// Serial converter sequencer: host port, debounce, SAR control
//
// Operation
// - Ten-bit successive approximation per conversion
// - Select one of eleven inputs or self-test
// - Sample and hold runs without host command
// - Result output is three-state
// - Address shifts in while result shifts out
// - Ignore start toggle three clocks after select falls
// - Result MSB appears once select is low
// - Nine bits follow on first falling edges
// - Tenth falling edge starts 44-cycle conversion
// - Convert channel latched when conversion starts
// - Address bits captured on rising shift edges
// - Out-of-range inputs saturate to ones or zeros
`timescale 1ns/10ps
`include "sacs_consts.svh"
module sacs_top
    import sacs_pkg::*;
(
    // Conversion clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // Host serial port, shift clock domain
    input wire logic shiftClk,
    input wire logic selectN,
    input wire logic addrIn,
    output logic resultOut,
    output logic resultOutEn,
    // Analog front end
    output logic [3:0] muxSel,
    output logic sampleHold,
    output logic [9:0] dacCode,
    input wire sacs_analog_t analogIn,
    // Completed results stream
    output logic resValid,
    input wire logic resReady,
    output sacs_result_t resData
);
    ///////////////////////////////////////////////////////////////////////
    // Link side on the shift clock, plus the held result on ref_clk; selectN high clears it, except the start toggle and held result, which only rst clears
    logic [3:0] bitCnt_r;
    logic [3:0] addrShift_r;
    logic [9:0] outShift_r;
    logic startTog_r;
    logic [9:0] resultHold_r;

    function automatic logic [9:0] sat(input logic [9:0] code,
                                       input sacs_analog_t a);
        if (a.aboveRef)
            sat = `SACS_ALL_ONES;
        else if (a.belowRef)
            sat = `SACS_ALL_ZEROS;
        else
            sat = code;
    endfunction

    // Codes past the self-test code fall back to the self-test level
    function automatic logic [3:0] chan_of(input logic [3:0] code);
        if (code > `SACS_SELFTEST_CH)
            chan_of = `SACS_SELFTEST_CH;
        else
            chan_of = code;
    endfunction

    // Last cycle of the conversion
    function automatic logic is_last(input sacs_state_t s,
                                     input logic [5:0] n);
        is_last = (s == SACS_CONVERT) &&
                  (n == 6'(`SACS_CONV_CYC - 1));
    endfunction

    always_ff @(posedge shiftClk)
    begin
        if (selectN)
        begin
            addrShift_r <= 4'h0;
        end
        else if (bitCnt_r < `SACS_ADDR_W)
        begin
            addrShift_r <= {addrShift_r[2:0], addrIn};
        end
    end

    always_ff @(negedge shiftClk or posedge selectN)
    begin
        if (selectN)
        begin
            bitCnt_r <= 4'h0;
            outShift_r <= 10'h000;
        end
        else if (bitCnt_r < `SACS_START_EDGE)
        begin
            bitCnt_r <= bitCnt_r + 4'h1;
            if (bitCnt_r == 4'h0)
                outShift_r <= {resultHold_r[8:0], 1'b0};
            else
                outShift_r <= {outShift_r[8:0], 1'b0};
        end
    end

    always_ff @(negedge shiftClk or posedge rst)
    begin
        if (rst)
            startTog_r <= 1'b0;
        else if (!selectN && bitCnt_r == `SACS_START_EDGE - 1)
            startTog_r <= ~startTog_r;
    end

    // MSB straight from the held result before the first fall
    assign resultOut = (bitCnt_r == 4'h0) ? resultHold_r[9]
                                          : outShift_r[9];
    assign resultOutEn = ~selectN;

    ///////////////////////////////////////////////////////////////////////
    // Conversion side, on ref_clk
    logic selSync;
    logic startSync;
    logic startSeen_r;
    logic [1:0] debCnt_r;
    logic debDone_r;
    sacs_state_t state_r;
    logic [5:0] cycCnt_r;
    logic [3:0] bitIdx_r;
    logic [9:0] sar_r;
    logic [3:0] convCh_r;
    logic startEv;
    logic startNow;
    logic convLast;

    sacs_sync u_selSync
    (
        .clk(ref_clk),
        .rst(rst),
        .din(~selectN),
        .dout(selSync)
    );

    sacs_sync u_startSync
    (
        .clk(ref_clk),
        .rst(rst),
        .din(startTog_r),
        .dout(startSync)
    );

    // The shift side has no clock before its first rise, so the
    // select debounce gates the start toggle here instead
    assign startEv = (startSync ^ startSeen_r) && debDone_r;
    assign startNow = (state_r == SACS_IDLE) && startEv;
    assign convLast = is_last(state_r, cycCnt_r);

    always_ff @(posedge ref_clk)
    begin
        if (rst || !selSync)
        begin
            debCnt_r <= 2'h0;
            debDone_r <= 1'b0;
        end
        else if (debCnt_r != 2'(`SACS_DEBOUNCE_CYC - 1))
        begin
            debCnt_r <= debCnt_r + 2'h1;
        end
        else
        begin
            debDone_r <= 1'b1;
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (rst)
            startSeen_r <= 1'b0;
        else
            startSeen_r <= startSync;
    end

    // Sequencer state and cycle count
    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            state_r <= SACS_IDLE;
            cycCnt_r <= 6'h00;
        end
        else
        begin
            unique case (state_r)
                SACS_IDLE:
                begin
                    cycCnt_r <= 6'h00;
                    if (startEv)
                        state_r <= SACS_SAMPLE;
                end
                SACS_SAMPLE:
                begin
                    cycCnt_r <= cycCnt_r + 6'h01;
                    if (cycCnt_r == 6'(`SACS_SAMPLE_CYC - 1))
                        state_r <= SACS_CONVERT;
                end
                SACS_CONVERT:
                begin
                    cycCnt_r <= cycCnt_r + 6'h01;
                    if (convLast)
                        state_r <= SACS_IDLE;
                end
            endcase
        end
    end

    // Trial bits, one a cycle once sampling is over
    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            sar_r <= 10'h000;
            bitIdx_r <= 4'h0;
        end
        else if (startNow)
        begin
            sar_r <= 10'h200;
            bitIdx_r <= 4'h9;
        end
        else if (state_r == SACS_CONVERT && bitIdx_r != 4'hF)
        begin
            // Keep or drop trial bit, try the next one
            if (!analogIn.compHigh)
                sar_r[bitIdx_r] <= 1'b0;
            if (bitIdx_r != 4'h0)
                sar_r[bitIdx_r - 4'h1] <= 1'b1;
            bitIdx_r <= bitIdx_r - 4'h1;
        end
    end

    // Address word has settled six rises before the start toggle
    always_ff @(posedge ref_clk)
    begin
        if (rst)
            convCh_r <= 4'h0;
        else if (startNow)
            convCh_r <= chan_of(addrShift_r);
    end

    // Result kept for the next transfer's shift-out
    always_ff @(posedge ref_clk)
    begin
        if (rst)
            resultHold_r <= 10'h000;
        else if (convLast)
            resultHold_r <= sat(sar_r, analogIn);
    end

    assign muxSel = convCh_r;
    assign sampleHold = (state_r == SACS_SAMPLE);
    assign dacCode = sar_r;

    ///////////////////////////////////////////////////////////////////////
    // Finished results into the buffer
    logic pushValid_r;
    logic bufReady;
    sacs_result_t pushData_r;

    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            pushValid_r <= 1'b0;
            pushData_r <= '0;
        end
        else if (convLast)
        begin
            // A result finishing while this slot still waits replaces it
            pushValid_r <= 1'b1;
            pushData_r <= {convCh_r, sat(sar_r, analogIn)};
        end
        else if (bufReady)
        begin
            pushValid_r <= 1'b0;
        end
    end

    sacs_buf2 u_buf
    (
        .clk(ref_clk),
        .rst(rst),
        .inValid(pushValid_r),
        .inReady(bufReady),
        .inData(pushData_r),
        .outValid(resValid),
        .outReady(resReady),
        .outData(resData)
    );
endmodule // sacs_top

// File: src/sacs_consts.svh
// Constants of the serial converter sequencer
`ifndef SACS_CONSTS_SVH
`define SACS_CONSTS_SVH
`define SACS_RES_W 10
`define SACS_ADDR_W 4
`define SACS_NUM_INPUTS 11
`define SACS_SELFTEST_CH 4'hB
`define SACS_DEBOUNCE_CYC 3
`define SACS_CONV_CYC 44
`define SACS_START_EDGE 10
`define SACS_ALL_ONES 10'h3FF
`define SACS_ALL_ZEROS 10'h000
`define SACS_SAMPLE_CYC 8
`endif

// File: src/sacs_pkg.sv
// Types of the serial converter sequencer
package sacs_pkg;
    typedef enum logic [1:0] {
        SACS_IDLE,
        SACS_SAMPLE,
        SACS_CONVERT
    } sacs_state_t;

    typedef struct packed {
        logic [3:0] channel;
        logic [9:0] data;
    } sacs_result_t;

    typedef struct packed {
        logic aboveRef;
        logic belowRef;
        logic compHigh;
    } sacs_analog_t;
endpackage

// File: src/sacs_sync.sv
// Two-flop synchroniser for a level
`timescale 1ns/10ps
module sacs_sync
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Level
    input wire logic din,
    output logic dout
);
    logic meta_r;

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            meta_r <= 1'b0;
            dout <= 1'b0;
        end
        else
        begin
            meta_r <= din;
            dout <= meta_r;
        end
    end
endmodule // sacs_sync

// File: src/sacs_buf2.sv
// Two-entry valid/ready buffer
`timescale 1ns/10ps
`include "sacs_consts.svh"
module sacs_buf2
    import sacs_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Fill side
    input wire logic inValid,
    output logic inReady,
    input wire sacs_result_t inData,
    // Drain side
    output logic outValid,
    input wire logic outReady,
    output sacs_result_t outData
);
    sacs_result_t mem [2];
    logic wrPtr_r;
    logic rdPtr_r;
    logic [1:0] count_r;
    logic push;
    logic pop;

    assign inReady = (count_r != 2'h2);
    assign outValid = (count_r != 2'h0);
    assign outData = mem[rdPtr_r];
    assign push = inValid && inReady;
    assign pop = outValid && outReady;

    always_ff @(posedge clk)
    begin
        if (push)
        begin
            mem[wrPtr_r] <= inData;
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            wrPtr_r <= 1'b0;
            rdPtr_r <= 1'b0;
            count_r <= 2'h0;
        end
        else
        begin
            if (push)
            begin
                wrPtr_r <= ~wrPtr_r;
            end
            if (pop)
            begin
                rdPtr_r <= ~rdPtr_r;
            end
            if (push && !pop)
            begin
                count_r <= count_r + 2'h1;
            end
            else if (pop && !push)
            begin
                count_r <= count_r - 2'h1;
            end
        end
    end
endmodule // sacs_buf2

// File: test/sacs_checker_assertions.sv
// Concurrent checks on the converter sequencer ports
`timescale 1ns/10ps
module sacs_checker
    import sacs_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // Host port
    input wire logic shiftClk,
    input wire logic selectN,
    input wire logic addrIn,
    input wire logic resultOut,
    input wire logic resultOutEn,
    // Front end
    input wire logic [3:0] muxSel,
    input wire logic sampleHold,
    input wire logic [9:0] dacCode,
    input wire sacs_analog_t analogIn,
    // Results
    input wire logic resValid,
    input wire logic resReady,
    input wire sacs_result_t resData
);
default clocking @(posedge ref_clk); endclocking
default disable iff (rst);
// Sample phase then hold released
sequence s_sample_run;
    sampleHold [*8] ##1 !sampleHold;
endsequence
a_float_when_high: assert property (selectN |-> !resultOutEn)
    else $error("result driven while deselected");
a_drive_when_low: assert property (!selectN |-> resultOutEn)
    else $error("result not driven while selected");
a_sample_eight: assert property ($rose(sampleHold) |-> s_sample_run)
    else $error("sample phase length wrong");
a_conv_length: assert property ($rose(sampleHold) |-> ##[40:50] resValid)
    else $error("conversion did not finish in time");
a_chan_hold: assert property (sampleHold && $past(sampleHold) |-> $stable(muxSel))
    else $error("channel moved during sampling");
a_mux_range: assert property (muxSel <= 4'hB)
    else $error("channel select out of range");
a_stall_keep: assert property (resValid && !resReady |=>
    resValid && $stable(resData))
    else $error("result lost while stalled");
a_res_chan: assert property (resValid |-> resData.channel <= 4'hB)
    else $error("result channel out of range");
endmodule // sacs_checker
bind sacs_top sacs_checker sacs_checker_i (.ref_clk(ref_clk), .rst(rst),
    .shiftClk(shiftClk), .selectN(selectN), .addrIn(addrIn),
    .resultOut(resultOut), .resultOutEn(resultOutEn), .muxSel(muxSel),
    .sampleHold(sampleHold), .dacCode(dacCode), .analogIn(analogIn),
    .resValid(resValid), .resReady(resReady), .resData(resData));

// File: test/sacs_host_model.sv
// Host processor model driving the serial port
`timescale 1ns/10ps
module sacs_host_model
(
    // Serial port outputs
    output logic shiftClk,
    output logic selectN,
    output logic addrIn,
    // Shared result line
    input wire logic resultOut,
    input wire logic resultOutEn
);
wire pinLine = resultOutEn ? resultOut : 1'bz;
initial
begin
    shiftClk = 0;
    selectN = 0;
    addrIn = 0;
    // Raise select once so the link side starts cleared
    #1 selectN = 1;
end
// One transfer: address in, previous result out
task xfer(input logic [3:0] ch, output logic [9:0] got);
    integer k;
    selectN = 0;
    #120;
    for (k = 0; k < 10; k++)
    begin
        addrIn = (k < 4) ? ch[3 - k] : ~addrIn;
        #80 shiftClk = 1;
        got[9 - k] = pinLine;
        #80 shiftClk = 0;
    end
    addrIn = ~addrIn;
    #400;
    selectN = 1;
    #160;
endtask
endmodule // sacs_host_model

// File: test/serial_adc_conversion_sequencer_bench.sv
// Self-checking bench for the converter sequencer
`timescale 1ns/10ps
module serial_adc_conversion_sequencer_bench
    import sacs_pkg::*;
;
logic ref_clk = 0;
logic rst = 0;
logic resReady = 0;
sacs_analog_t analogIn = '0;
logic shiftClk, selectN, addrIn, resultOut, resultOutEn;
logic sampleHold, resValid;
logic [3:0] muxSel;
logic [9:0] dacCode, got;
sacs_result_t resData;
int fails = 0;
int samples_checked = 0;
always #2 ref_clk = ~ref_clk;
sacs_top sacs_top_i (.ref_clk(ref_clk), .rst(rst), .shiftClk(shiftClk),
    .selectN(selectN), .addrIn(addrIn), .resultOut(resultOut),
    .resultOutEn(resultOutEn), .muxSel(muxSel), .sampleHold(sampleHold),
    .dacCode(dacCode), .analogIn(analogIn), .resValid(resValid),
    .resReady(resReady), .resData(resData));
sacs_host_model sacs_host_model_i (.shiftClk(shiftClk), .selectN(selectN),
    .addrIn(addrIn), .resultOut(resultOut), .resultOutEn(resultOutEn));
////////////////////////////////////////////////////////////////////////////
task check(input string name, input logic [15:0] seen, exp);
    samples_checked++;
    if (seen !== exp)
    begin
        fails++;
        $display("BAD %s exp %h seen %h", name, exp, seen);
    end
endtask
task tally_and_finish;
    if (fails == 0 && samples_checked > 0)
        $display("TB: PASS");
    else
        $display("TB: FAIL");
    $finish;
endtask
// Take one result from the stream, stalling first
task pop(input logic [3:0] ch, input logic [9:0] data, input logic chk);
    integer n;
    for (n = 0; n < 200 && resValid !== 1'b1; n++)
    begin
        @(posedge ref_clk);
        #1;
    end
    if (n == 200)
    begin
        fails++;
        tally_and_finish;
    end
    else
    begin
        check("resChan", resData.channel, ch);
        if (chk)
            check("resData", resData.data, data);
        @(posedge ref_clk) #1 resReady = 1;
        @(posedge ref_clk) #1 resReady = 0;
    end
endtask
////////////////////////////////////////////////////////////////////////////
task t_idle;
    check("enIdle", resultOutEn, 1'b0);
    check("valIdle", resValid, 1'b0);
endtask
// Two saturated conversions held by a stalled receiver
task t_stalled_pair;
    @(posedge ref_clk) #1 analogIn = 3'b100;
    sacs_host_model_i.xfer(4'h5, got);
    @(posedge ref_clk) #1 analogIn = 3'b010;
    sacs_host_model_i.xfer(4'hB, got);
    check("shiftOut", got, 10'h3FF);
    check("muxSel", muxSel, 4'hB);
    check("dacZero", dacCode, 10'h000);
    pop(4'h5, 10'h3FF, 1);
    pop(4'hB, 10'h000, 1);
    check("empty", resValid, 1'b0);
endtask
// Previous zero result shifts out, address order kept
task t_shift_out;
    @(posedge ref_clk) #1 analogIn = 3'b001;
    sacs_host_model_i.xfer(4'h2, got);
    check("zeroOut", got, 10'h000);
    check("muxSel2", muxSel, 4'h2);
    pop(4'h2, 10'h3FF, 1);
    check("enOff", resultOutEn, 1'b0);
    check("dacOnes", dacCode, 10'h3FF);
endtask
initial
begin
    #1 rst = 1;
    repeat (20) @(posedge ref_clk);
    #1 rst = 0;
    t_idle;
    t_stalled_pair;
    t_shift_out;
    tally_and_finish;
end
endmodule // serial_adc_conversion_sequencer_bench
